// [core/crmbs_top.sv]
// receive acceptance masks, mask compare and per-buffer full/overflow flags
// assumes store and compare requests come from logic on clk_sys
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module crmbs_top
   import crmbs_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic resetn,
   // axi write address
   input wire logic [CRMBS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi read address
   input wire logic [CRMBS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // filter compare
   input wire logic matchReq,
   input wire logic [CRMBS_ID_W-1:0] rxId,
   input wire logic rxIde,
   input wire logic [CRMBS_ID_W-1:0] filterId,
   input wire logic filterIde,
   input wire logic [1:0] maskSelect,
   output logic matchDone,
   output logic matchHit,
   // buffer store
   input wire logic storeValid,
   input wire logic [CRMBS_IDX_W-1:0] storeIndex,
   output logic [CRMBS_BUFS-1:0] bufferFull,
   // interrupt
   output logic irq
);

   // every register of the block lives in this one record
   typedef struct packed {
      logic [CRMBS_MASKS-1:0][15:0] maskStd;
      logic [CRMBS_MASKS-1:0][15:0] maskExt;
      logic [CRMBS_BUFS-1:0] full;
      logic [CRMBS_BUFS-1:0] ovf;
      logic [CRMBS_IRQ_W-1:0] irqStat;
      logic [CRMBS_IRQ_W-1:0] irqMask;
      logic irq;
      logic matchDone;
      logic matchHit;
      logic awReady;
      logic awHeld;
      logic [CRMBS_ADDR_W-1:0] awAddr;
      logic wReady;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } crmbs_state_s;

   crmbs_state_s s_q;
   crmbs_state_s s_d;

   // per-buffer flag terms
   logic [CRMBS_BUFS-1:0] setFull;
   logic [CRMBS_BUFS-1:0] setOvf;
   logic [CRMBS_BUFS-1:0] keepFull;
   logic [CRMBS_BUFS-1:0] keepOvf;
   logic [CRMBS_IRQ_W-1:0] irqEvt;
   logic [CRMBS_IRQ_W-1:0] irqClr;

   // mask compare terms
   logic selValid;
   logic [1:0] selIdx;
   logic [15:0] selStd;
   logic [15:0] selExt;
   logic [CRMBS_ID_W-1:0] cmpMask;
   logic idEqual;
   logic typeOk;

   // axi handshake terms
   logic awTake;
   logic wTake;
   logic arTake;

   // byte-lane merge for plain read/write registers
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction

   // clear-only lanes: a written 0 clears, a written 1 or an idle lane keeps
   function automatic logic [15:0] keep16(input logic [31:0] data,
                                          input logic [3:0] strb);
      logic [15:0] res;
      res = 16'hffff;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction

   // unaligned or out-of-range mask offsets get the error answer
   function automatic logic isMaskAddr(input logic [CRMBS_ADDR_W-1:0] a);
      return (a >= ADDR_MASK_BASE) && (a < ADDR_MASK_END) &&
             (a[1:0] == 2'h0);
   endfunction

   // per-buffer set terms from the store port
   for (genvar i = 0; i < CRMBS_BUFS; i++) begin : g_buf
      assign setFull[i] = storeValid &&
                          (storeIndex == CRMBS_IDX_W'(i));
      // overflow needs the flag already set before this store
      assign setOvf[i] = setFull[i] && s_q.full[i];
   end

   // mask compare; code 3 of the selector picks no mask and never matches
   always_comb begin
      selValid = (32'(maskSelect) < CRMBS_MASKS);
      selIdx = selValid ? maskSelect : 2'h0;
      selStd = s_q.maskStd[selIdx];
      selExt = s_q.maskExt[selIdx];
      cmpMask = {selStd[STD_ID_MSB:STD_ID_LSB],
                 selStd[STD_EXT_HI_MSB:0], selExt};
      // standard frames carry no extended bits, so those are not compared
      if (!rxIde) begin
         cmpMask[ID_EXT_W-1:0] = '0;
      end
      idEqual = (((rxId ^ filterId) & cmpMask) == '0);
      // mode clear: either frame type passes once the ids agree
      typeOk = !selStd[STD_MODE_BIT] || (rxIde == filterIde);
   end

   always_comb begin
      s_d = s_q;
      // defaults: keep every flag, clear no status
      keepFull = '1;
      keepOvf = '1;
      irqClr = '0;
      awTake = s_axi_awvalid && s_q.awReady;
      wTake = s_axi_wvalid && s_q.wReady;
      arTake = s_axi_arvalid && s_q.arReady;

      // write channels are taken independently, in either order
      if (awTake) begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = s_axi_awaddr;
      end
      if (wTake) begin
         s_d.wHeld = 1'b1;
         s_d.wData = s_axi_wdata;
         s_d.wStrb = s_axi_wstrb;
      end
      if (s_q.bValid && s_axi_bready) begin
         s_d.bValid = 1'b0;
      end
      // the update waits for both halves, so decode sees held values only
      if (s_q.awHeld && s_q.wHeld && !s_q.bValid) begin
         s_d.awHeld = 1'b0;
         s_d.wHeld = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp = RESP_OKAY;
         if (isMaskAddr(s_q.awAddr)) begin
            if (32'(s_q.awAddr[4:3]) >= CRMBS_MASKS) begin
               s_d.bResp = RESP_SLVERR;
            end else if (s_q.awAddr[2]) begin
               s_d.maskExt[s_q.awAddr[4:3]] =
                  merge16(s_q.maskExt[s_q.awAddr[4:3]],
                          s_q.wData, s_q.wStrb);
            end else begin
               s_d.maskStd[s_q.awAddr[4:3]] =
                  merge16(s_q.maskStd[s_q.awAddr[4:3]],
                          s_q.wData, s_q.wStrb) & STD_WRITABLE;
            end
         end else begin
            unique case (s_q.awAddr)
               ADDR_FULL_LOW: begin
                  keepFull[15:0] = keep16(s_q.wData, s_q.wStrb);
               end
               ADDR_FULL_HIGH: begin
                  keepFull[31:16] = keep16(s_q.wData, s_q.wStrb);
               end
               ADDR_OVF_LOW: begin
                  keepOvf[15:0] = keep16(s_q.wData, s_q.wStrb);
               end
               ADDR_OVF_HIGH: begin
                  keepOvf[31:16] = keep16(s_q.wData, s_q.wStrb);
               end
               ADDR_IRQ_STATUS: begin
                  // status clears only by reading it
               end
               ADDR_IRQ_MASK: begin
                  if (s_q.wStrb[0]) begin
                     s_d.irqMask = s_q.wData[CRMBS_IRQ_W-1:0];
                  end
               end
               // refused writes still answer, with an error code
               default: begin
                  s_d.bResp = RESP_SLVERR;
               end
            endcase
         end
      end

      // read channel: data is captured at the address edge
      if (s_q.rValid && s_axi_rready) begin
         s_d.rValid = 1'b0;
      end
      if (arTake) begin
         s_d.rValid = 1'b1;
         s_d.rResp = RESP_OKAY;
         // upper half of every read is zero
         s_d.rData = '0;
         if (isMaskAddr(s_axi_araddr)) begin
            if (32'(s_axi_araddr[4:3]) >= CRMBS_MASKS) begin
               s_d.rResp = RESP_SLVERR;
            end else if (s_axi_araddr[2]) begin
               s_d.rData[15:0] = s_q.maskExt[s_axi_araddr[4:3]];
            end else begin
               s_d.rData[15:0] = s_q.maskStd[s_axi_araddr[4:3]];
            end
         end else begin
            unique case (s_axi_araddr)
               ADDR_FULL_LOW: begin
                  s_d.rData[15:0] = s_q.full[15:0];
               end
               ADDR_FULL_HIGH: begin
                  s_d.rData[15:0] = s_q.full[31:16];
               end
               ADDR_OVF_LOW: begin
                  s_d.rData[15:0] = s_q.ovf[15:0];
               end
               ADDR_OVF_HIGH: begin
                  s_d.rData[15:0] = s_q.ovf[31:16];
               end
               ADDR_IRQ_STATUS: begin
                  s_d.rData[CRMBS_IRQ_W-1:0] = s_q.irqStat;
                  // a status read clears it; an event in this cycle lands
                  irqClr = '1;
               end
               ADDR_IRQ_MASK: begin
                  s_d.rData[CRMBS_IRQ_W-1:0] = s_q.irqMask;
               end
               // unmapped reads answer zero with an error code
               default: begin
                  s_d.rResp = RESP_SLVERR;
               end
            endcase
         end
      end

      // a store in the same cycle as a software clear wins
      s_d.full = (s_q.full & keepFull) | setFull;
      s_d.ovf = (s_q.ovf & keepOvf) | setOvf;
      // sticky event bits, one per kind of event
      irqEvt = '0;
      irqEvt[IRQ_STORED_BIT] = |setFull;
      irqEvt[IRQ_OVERFLOW_BIT] = |setOvf;
      s_d.irqStat = (s_q.irqStat & ~irqClr) | irqEvt;
      // irq follows the next status, so it rises together with the bit
      s_d.irq = |(s_d.irqStat & s_d.irqMask);

      // compare answer one cycle after the request
      s_d.matchDone = matchReq;
      s_d.matchHit = matchReq && selValid && idEqual && typeOk;

      // one write and one read in flight at a time
      s_d.awReady = !s_d.awHeld && !s_d.bValid;
      s_d.wReady = !s_d.wHeld && !s_d.bValid;
      s_d.arReady = !s_d.rValid;
   end

   // masks have no documented reset value; they start at zero here
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.full <= {RESET_FLAGS, RESET_FLAGS};
         s_q.ovf <= {RESET_FLAGS, RESET_FLAGS};
         s_q.maskStd <= {CRMBS_MASKS{RESET_MASK}};
         s_q.maskExt <= {CRMBS_MASKS{RESET_MASK}};
      end else begin
         s_q <= s_d;
      end
   end

   // bus outputs
   assign s_axi_awready = s_q.awReady;
   assign s_axi_wready = s_q.wReady;
   assign s_axi_bresp = s_q.bResp;
   assign s_axi_bvalid = s_q.bValid;
   assign s_axi_arready = s_q.arReady;
   assign s_axi_rdata = s_q.rData;
   assign s_axi_rresp = s_q.rResp;
   assign s_axi_rvalid = s_q.rValid;

   // compare, flag and interrupt outputs
   assign matchDone = s_q.matchDone;
   assign matchHit = s_q.matchHit;
   assign bufferFull = s_q.full;
   assign irq = s_q.irq;

endmodule // crmbs_top
`default_nettype wire

// [inc/crmbs_pkg.sv]
// constants for the receive mask and buffer status block
// assumes an axi4-lite master with 8-bit byte addresses and 32-bit data
package crmbs_pkg;
   // sizes
   localparam int unsigned CRMBS_MASKS = 3;
   localparam int unsigned CRMBS_BUFS = 32;
   localparam int unsigned CRMBS_IDX_W = 5;
   localparam int unsigned CRMBS_ADDR_W = 8;
   localparam int unsigned CRMBS_ID_W = 29;
   localparam int unsigned CRMBS_IRQ_W = 2;
   // register byte offsets
   localparam logic [7:0] ADDR_MASK_BASE = 8'h00;
   localparam logic [7:0] ADDR_MASK_END = 8'h18;
   localparam logic [7:0] ADDR_FULL_LOW = 8'h20;
   localparam logic [7:0] ADDR_FULL_HIGH = 8'h24;
   localparam logic [7:0] ADDR_OVF_LOW = 8'h28;
   localparam logic [7:0] ADDR_OVF_HIGH = 8'h2c;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;
   // standard mask register fields
   localparam int unsigned STD_ID_LSB = 5;
   localparam int unsigned STD_ID_MSB = 15;
   localparam int unsigned STD_MODE_BIT = 3;
   localparam int unsigned STD_EXT_HI_MSB = 1;
   localparam logic [15:0] STD_WRITABLE = 16'hffeb;
   // received identifier layout: standard bits above the 18 extended bits
   localparam int unsigned ID_EXT_W = 18;
   // interrupt status bits
   localparam int unsigned IRQ_STORED_BIT = 0;
   localparam int unsigned IRQ_OVERFLOW_BIT = 1;
   // reset values
   localparam logic [15:0] RESET_FLAGS = 16'h0000;
   localparam logic [15:0] RESET_MASK = 16'h0000;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [tb/crmbs_rx_model.sv]
// stand-in for the frame receiver that stores messages into buffers
// assumes calls start just after a rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module crmbs_rx_model
   import crmbs_pkg::*;
(
   // system
   input wire logic clk_sys,
   // store
   output var logic storeValid,
   output var logic [CRMBS_IDX_W-1:0] storeIndex
);
   initial begin
      storeValid = 1'b0;
      storeIndex = '0;
   end
   // one pulse, then an idle edge so calls never collide
   task automatic store(input logic [CRMBS_IDX_W-1:0] idx);
      storeValid <= 1'b1;
      storeIndex <= idx;
      @(posedge clk_sys);
      storeValid <= 1'b0;
      storeIndex <= ~idx;
      @(posedge clk_sys);
   endtask
endmodule // crmbs_rx_model
`default_nettype wire

// [tb/crmbs_top_sva.sv]
// checker on the ports of the receive mask and buffer status block
// assumes one clock domain; bound into crmbs_top
`timescale 1ns/1ps
`default_nettype none
module crmbs_top_sva
   import crmbs_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic resetn,
   // axi
   input wire logic s_axi_wvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // compare and store
   input wire logic matchReq,
   input wire logic [1:0] maskSelect,
   input wire logic matchDone,
   input wire logic matchHit,
   input wire logic storeValid,
   input wire logic [CRMBS_IDX_W-1:0] storeIndex,
   input wire logic [CRMBS_BUFS-1:0] bufferFull
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   a_done_follows: assert property (matchReq |=> matchDone)
      else $error("no compare answer");
   a_done_unasked: assert property (!matchReq |=> !matchDone)
      else $error("compare answer without request");
   a_hit_in_done: assert property (matchHit |-> matchDone)
      else $error("hit outside answer");
   a_slot_three_miss: assert property (
      matchReq && maskSelect == 2'h3 |=> !matchHit)
      else $error("reserved mask slot matched");
   a_store_sets_full: assert property (
      storeValid |=> bufferFull[$past(storeIndex)])
      else $error("store left buffer empty");
   // a full flag may only drop right after a software write
   a_full_sw_only: assert property (
      |($past(bufferFull) & ~bufferFull) |->
      $past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
      else $error("full flag dropped without a write");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read not answered");
   a_write_single: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("write response repeated");
endmodule // crmbs_top_sva
bind crmbs_top crmbs_top_sva crmbs_top_sva_i (.*);
`default_nettype wire

// [tb/tb_can_rx_mask_buffer_status.sv]
// self-checking bench for the receive mask and buffer status block
// assumes crmbs_top, its package and the receiver model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin testsRun++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_can_rx_mask_buffer_status;
   import crmbs_pkg::*;
   logic clk_sys = 1'b0, resetn = 1'b0, matchReq = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, bufferFull;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, maskSelect = 2'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, matchDone, matchHit, irq, storeValid;
   logic rxIde = 1'b0, filterIde = 1'b0;
   logic [28:0] rxId = 29'h0, filterId = 29'h0;
   logic [4:0] storeIndex;
   int failures = 0, testsRun = 0;
   crmbs_top crmbs_top_i (.*);
   crmbs_rx_model rx (.clk_sys, .storeValid, .storeIndex);
   initial forever #20 clk_sys = ~clk_sys;
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s, input logic [1:0] er);
      int n;
      logic aw, w, b;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(negedge clk_sys);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         if (b) `CHK(s_axi_bresp, er)
         @(posedge clk_sys);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         n++;
      end while (!b && n < 40);
      `CHK(b, 1'b1)
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      int n;
      logic t, r;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(negedge clk_sys);
         t = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         if (r) `CHK({s_axi_rresp, s_axi_rdata}, {er, ed})
         @(posedge clk_sys);
         if (t) s_axi_arvalid <= 1'b0;
         n++;
      end while (!r && n < 40);
      `CHK(r, 1'b1)
   endtask
   task automatic cmp(input logic [1:0] m, input logic [28:0] a,
         input logic ai, input logic fi, input logic e);
      maskSelect <= m;
      rxId <= a;
      rxIde <= ai;
      filterId <= 29'h15540000;
      filterIde <= fi;
      matchReq <= 1'b1;
      @(posedge clk_sys);
      matchReq <= 1'b0;
      @(negedge clk_sys);
      `CHK({matchDone, matchHit}, {1'b1, e})
      @(posedge clk_sys);
   endtask
   task automatic t_regs();
      `CHK(bufferFull, 32'h0)
      for (int i = 0; i < 4; i++) begin
         rd(8'h20 + 8'(4 * i), 32'h0, RESP_OKAY);
      end
      wr(8'h08, 32'hffff, 4'h3, RESP_OKAY);
      rd(8'h08, 32'hffeb, RESP_OKAY);
      wr(8'h0c, 32'hffff, 4'h3, RESP_OKAY);
      rd(8'h0c, 32'hffff, RESP_OKAY);
      wr(8'h00, 32'hffe0, 4'h3, RESP_OKAY);
      // third mask: type match only, every id bit a don't-care
      wr(8'h10, 32'h0008, 4'h3, RESP_OKAY);
      rd(8'h10, 32'h0008, RESP_OKAY);
      rd(8'h18, 32'h0, RESP_SLVERR);
      wr(8'h40, 32'h0, 4'hf, RESP_SLVERR);
      $display("test regs done");
   endtask
   task automatic t_flags();
      wr(ADDR_IRQ_MASK, 32'h3, 4'h1, RESP_OKAY);
      rx.store(5'h00);
      rx.store(5'h11);
      `CHK({irq, bufferFull}, {1'b1, 32'h00020001})
      rx.store(5'h11);
      rx.store(5'h03);
      rx.store(5'h03);
      rd(ADDR_FULL_LOW, 32'h9, RESP_OKAY);
      rd(ADDR_FULL_HIGH, 32'h2, RESP_OKAY);
      rd(ADDR_OVF_LOW, 32'h8, RESP_OKAY);
      rd(ADDR_OVF_HIGH, 32'h2, RESP_OKAY);
      rd(ADDR_IRQ_STATUS, 32'h3, RESP_OKAY);
      rd(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
      `CHK(irq, 1'b0)
      wr(ADDR_FULL_HIGH, 32'hfffd, 4'h3, RESP_OKAY);
      // a disabled lane must keep its flags
      wr(ADDR_FULL_LOW, 32'h0, 4'h2, RESP_OKAY);
      `CHK(bufferFull, 32'h9)
      wr(ADDR_OVF_LOW, 32'h0, 4'h1, RESP_OKAY);
      rd(ADDR_OVF_LOW, 32'h0, RESP_OKAY);
      // a clear and a store landing on the same edge: the store wins
      fork
         wr(ADDR_FULL_LOW, 32'hfffe, 4'h3, RESP_OKAY);
         begin
            @(posedge clk_sys);
            rx.store(5'h00);
         end
      join
      `CHK(bufferFull, 32'h9)
      rd(ADDR_OVF_LOW, 32'h1, RESP_OKAY);
      $display("test flags done");
   endtask
   task automatic t_match();
      cmp(2'h0, 29'h15540123, 1'b1, 1'b1, 1'b1);
      cmp(2'h0, 29'h15500000, 1'b1, 1'b1, 1'b0);
      cmp(2'h0, 29'h15540000, 1'b0, 1'b1, 1'b1);
      cmp(2'h1, 29'h15540001, 1'b1, 1'b1, 1'b0);
      cmp(2'h1, 29'h15550000, 1'b1, 1'b1, 1'b0);
      cmp(2'h1, 29'h15540000, 1'b0, 1'b1, 1'b0);
      cmp(2'h1, 29'h15540000, 1'b1, 1'b1, 1'b1);
      cmp(2'h2, 29'h0, 1'b0, 1'b0, 1'b1);
      cmp(2'h2, 29'h0, 1'b0, 1'b1, 1'b0);
      cmp(2'h3, 29'h15540000, 1'b1, 1'b1, 1'b0);
      $display("test match done");
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      t_regs();
      t_flags();
      t_match();
      finish_test();
   end
endmodule // tb_can_rx_mask_buffer_status
`default_nettype wire
